// ===== core/sac_core.sv
// conversion sequencing and serial result readout
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"
module sac_core #(
  parameter int CONV_CYCLES = `SAC_CONV_CYCLES,
  parameter bit BIPOLAR = `SAC_BIPOLAR_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic conv_start_n,
  input wire logic serial_clk,
  input wire logic [11:0] sample_in,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic serial_result_out,
  output logic serial_result_oe_n,
  output logic track_hold_r
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // reset levels match the idle pins, so no false edge follows reset
  logic [1:0] cs_sync_r;
  logic [1:0] sck_sync_r;
  logic cs_d_r;
  logic sck_d_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_sync_r <= 2'h3;
      sck_sync_r <= 2'h0;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_sync_r <= {cs_sync_r[0], conv_start_n};
      sck_sync_r <= {sck_sync_r[0], serial_clk};
      cs_d_r <= cs_sync_r[1];
      sck_d_r <= sck_sync_r[1];
    end
  end

  // ************************************************************
  // pin edge detect
  // ************************************************************
  wire cs_rise = cs_sync_r[1] & ~cs_d_r;
  wire cs_fall = ~cs_sync_r[1] & cs_d_r;
  wire sck_rise = sck_sync_r[1] & ~sck_d_r;
  wire sck_fall = ~sck_sync_r[1] & sck_d_r;

  // ************************************************************
  // two-entry buffer for converter samples
  // ************************************************************
  // a stalled load keeps the analog side from losing a word
  logic [11:0] buf_r [0:1];
  logic buf_wp_r;
  logic buf_rp_r;
  logic [1:0] buf_cnt_r;
  logic buf_pop;
  wire buf_push = sample_valid & sample_ready;
  wire buf_valid = buf_cnt_r != 2'h0;
  assign sample_ready = buf_cnt_r != 2'h2;
  logic [1:0] buf_cnt_nxt;
  // push and pop may fall in one cycle; the count then stands
  assign buf_cnt_nxt = buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buf_r[0] <= 12'h000;
      buf_r[1] <= 12'h000;
      buf_wp_r <= 1'b0;
      buf_rp_r <= 1'b0;
      buf_cnt_r <= 2'h0;
    end else begin
      if (buf_push) begin
        buf_r[buf_wp_r] <= sample_in;
        buf_wp_r <= ~buf_wp_r;
      end
      if (buf_pop) buf_rp_r <= ~buf_rp_r;
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  // ************************************************************
  // conversion timer
  // ************************************************************
  // start edges inside a conversion are ignored
  sac_pkg::sac_state_t state_r;
  logic [15:0] conv_cnt_r;
  wire conv_done = (state_r == sac_pkg::SAC_CONVERT) &&
                   (conv_cnt_r == 16'(CONV_CYCLES - 1));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= sac_pkg::SAC_TRACK;
      conv_cnt_r <= 16'h0000;
      track_hold_r <= 1'b0;
    end else begin
      case (state_r)
        sac_pkg::SAC_TRACK: begin
          conv_cnt_r <= 16'h0000;
          if (cs_rise) begin
            state_r <= sac_pkg::SAC_CONVERT;
            track_hold_r <= 1'b1;
          end
        end
        sac_pkg::SAC_CONVERT: begin
          conv_cnt_r <= conv_cnt_r + 16'h0001;
          // the host serial clock plays no part in this timing
          if (conv_done) begin
            state_r <= sac_pkg::SAC_TRACK;
            track_hold_r <= 1'b0;
          end
        end
        default: state_r <= sac_pkg::SAC_TRACK;
      endcase
    end
  end

  // ************************************************************
  // output register and serial shifter
  // ************************************************************
  // no end-of-conversion pin: the host times off conv_start_n
  logic [11:0] out_reg_r;
  logic [11:0] out_reg_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [11:0] shown_r;
  logic [11:0] shown_nxt;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [15:0] shift_r;
  logic [15:0] shift_nxt;
  logic drive_r;
  logic drive_nxt;
  logic out_bit_r;
  logic out_bit_nxt;
  localparam logic [4:0] FRAME_LAST = 5'(`SAC_FRAME_BITS);

  // ************************************************************
  // frame helpers
  // ************************************************************
  // a frame starts from an idle counter or straight after its last bit
  function automatic logic frame_start(input logic [4:0] cnt);
    frame_start = (cnt == 5'h00) || (cnt == FRAME_LAST);
  endfunction : frame_start

  // four leading zeros above the published result
  function automatic logic [15:0] frame_of(input logic [11:0] res);
    frame_of = {{`SAC_LEAD_ZEROS{1'b0}}, res};
  endfunction : frame_of

  // ************************************************************
  // decode of the serial pin
  // ************************************************************
  wire reading = bit_cnt_r != 5'h00;
  wire at_start = frame_start(bit_cnt_r);
  wire last_fall = sck_fall && (bit_cnt_r == FRAME_LAST);
  wire [15:0] shown_frame = frame_of(shown_r);
  // coding is done ahead of the buffer, so both variants pass the word as is
  wire [11:0] coded = BIPOLAR ? buf_r[buf_rp_r] : buf_r[buf_rp_r];

  // ************************************************************
  // output register publish
  // ************************************************************
  // the sample is captured at conversion end; only the publish waits
  // an empty buffer at conversion end keeps the old result
  assign buf_pop = conv_done & buf_valid;
  assign out_reg_nxt = buf_pop ? coded : out_reg_r;
  // publish when idle, at the end of a read, or when start falls
  wire load_now = pend_r & (~reading | last_fall | cs_fall);
  // a fresh end of conversion outranks a publish of the older word
  assign pend_nxt = conv_done ? 1'b1 : (load_now ? 1'b0 : pend_r);
  assign shown_nxt = load_now ? out_reg_r : shown_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_reg_r <= 12'h000;
      pend_r <= 1'b0;
      shown_r <= 12'h000;
    end else begin
      out_reg_r <= out_reg_nxt;
      pend_r <= pend_nxt;
      shown_r <= shown_nxt;
    end
  end

  // ************************************************************
  // bit counter and shifter
  // ************************************************************
  // counter wraps so extra clocks restart the frame
  assign bit_cnt_nxt = cs_fall ? 5'h00 :
                       sck_rise ? (at_start ? 5'h01 : bit_cnt_r + 5'h01) :
                       last_fall ? 5'h00 : bit_cnt_r;
  assign shift_nxt = (sck_rise && !cs_fall) ?
                     (at_start ? {shown_frame[14:0], 1'b0} : {shift_r[14:0], 1'b0}) :
                     (last_fall ? 16'h0000 : shift_r);
  // extra clocks drive the pin again until the restarted frame's last fall or until start falls
  assign drive_nxt = cs_fall ? 1'b0 :
                     sck_rise ? 1'b1 :
                     last_fall ? 1'b0 : drive_r;
  assign out_bit_nxt = sck_rise ? (at_start ? shown_frame[15] : shift_r[15]) :
                       out_bit_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
      drive_r <= 1'b0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      drive_r <= drive_nxt;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) out_bit_r <= 1'b0;
    else out_bit_r <= out_bit_nxt;
  end

  // ************************************************************
  // pins
  // ************************************************************
  // enable is low while the pin is driven
  assign serial_result_out = out_bit_r;
  assign serial_result_oe_n = ~drive_r;
endmodule : sac_core
`default_nettype wire

// ===== core/sac_map.svh
// clock rate, timing counts and frame layout of the conversion/readout block
//
// Contract
// - conv_start_n rising edge: hold, start conversion
// - conversion end returns track/hold to track
// - result loaded 6 us after rising edge
// - after sixteenth clock: reset, output released
// - extra clocks advance register past reset
// - conv_start_n falling edge resets shift counter
// - reading during conversion is permitted
// - no conversion-complete status output exists
// - bipolar variants emit twos complement codes
// - unipolar variants emit straight binary codes
// - data changes on serial clock rising edge
// - frame: four zeros, then result MSB first
// - load deferred while read runs, until end
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
`define SAC_CLK_MHZ 125
`define SAC_CONV_TIME_NS 6000
`define SAC_CONV_CYCLES ((`SAC_CONV_TIME_NS * `SAC_CLK_MHZ) / 1000)
`define SAC_FRAME_BITS 16
`define SAC_LEAD_ZEROS 4
`define SAC_RESULT_BITS 12
`define SAC_BIPOLAR_DEFAULT 1'b1
`endif

// ===== core/sac_pkg.sv
// types of the conversion/readout block
package sac_pkg;
  typedef enum logic [0:0] {
    SAC_TRACK = 1'b0,
    SAC_CONVERT = 1'b1
  } sac_state_t;
endpackage : sac_pkg

// ===== tb/sac_core_properties.sv
// port assertions of the conversion/readout block
`timescale 1ns/1ps
`default_nettype none
module sac_core_chk #(parameter int CONV_CYCLES = 750) (
  input wire logic clock,
  input wire logic rst,
  input wire logic conv_start_n,
  input wire logic serial_clk,
  input wire logic sample_ready,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n,
  input wire logic track_hold_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int hc_r;
  logic [4:0] fc_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hc_r <= 0;
      fc_r <= 5'h00;
    end else begin
      hc_r <= track_hold_r ? hc_r + 1 : 0;
      if ($fell(conv_start_n)) fc_r <= 5'h00;
      else if ($fell(serial_clk)) fc_r <= (fc_r == 5'h10) ? 5'h01 : fc_r + 5'h01;
    end
  end
  rst_idle_a: assert property ($fell(rst) |-> serial_result_oe_n && !track_hold_r && sample_ready)
    else $error("bad idle");
  start_hold_a: assert property ($rose(conv_start_n) && !track_hold_r |-> ##[1:5] track_hold_r)
    else $error("no hold");
  hold_cause_a: assert property ($rose(track_hold_r) |-> conv_start_n)
    else $error("stray hold");
  conv_len_a: assert property ($fell(track_hold_r) |-> hc_r == CONV_CYCLES)
    else $error("bad length");
  data_steady_a: assert property ($stable(serial_clk) [*6] ##0 !serial_result_oe_n
    |-> $stable(serial_result_out)) else $error("data moved");
  drive_begin_a: assert property ($rose(serial_clk) && serial_result_oe_n
    |-> ##[1:5] !serial_result_oe_n) else $error("no drive");
  frame_end_a: assert property ($stable(serial_clk) [*6] ##0 fc_r == 5'h10
    |-> serial_result_oe_n) else $error("not released");
  start_release_a: assert property ($fell(conv_start_n) && !serial_clk
    |-> ##[1:6] serial_result_oe_n) else $error("no reset");
endmodule : sac_core_chk
bind sac_core sac_core_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (.clock, .rst, .conv_start_n,
  .serial_clk, .sample_ready, .serial_result_out, .serial_result_oe_n, .track_hold_r);
`default_nettype wire

// ===== tb/sac_host.sv
// host model: start pulses and serial reads
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  input wire logic clock,
  input wire logic serial_result_out,
  input wire logic serial_result_oe_n,
  output logic conv_start_n,
  output logic serial_clk
);
  // a released line shows the inverse, so a stale bit never passes
  wire logic line = serial_result_oe_n ^ serial_result_out;
  initial conv_start_n = 1'b1;
  initial serial_clk = 1'b0;
  task automatic convert(input int lo);
    conv_start_n = 1'b0;
    repeat (lo) @(negedge clock);
    conv_start_n = 1'b1;
  endtask : convert
  task automatic read(input int n, output logic [15:0] w);
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      repeat (4) @(negedge clock);
      serial_clk = 1'b0;
      w = {w[14:0], line};
      repeat (4) @(negedge clock);
    end
  endtask : read
endmodule : sac_host
`default_nettype wire

// ===== tb/tb_sac_core.sv
// self-checking bench of the conversion/readout block
`timescale 1ns/1ps
`default_nettype none
module tb_sac_core;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sample_valid = 1'b0;
  logic [11:0] sample_in = 12'h000;
  logic [15:0] w;
  logic [11:0] q[$];
  logic [11:0] cur = 12'h000;
  int err_total = 0;
  int tests_run = 0;
  int seed = 28669;
  int cyc = 0;
  wire logic cs_n, sclk, rdy, sdo, oe_n, th;
  always #4 clock = ~clock;
  sac_core #(.CONV_CYCLES(20)) DUT (.clock(clock), .rst(rst), .conv_start_n(cs_n),
    .serial_clk(sclk), .sample_in(sample_in), .sample_valid(sample_valid), .sample_ready(rdy),
    .serial_result_out(sdo), .serial_result_oe_n(oe_n), .track_hold_r(th));
  sac_host host (.clock(clock), .serial_result_out(sdo), .serial_result_oe_n(oe_n),
    .conv_start_n(cs_n), .serial_clk(sclk));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic push;
    @(negedge clock);
    check("ready", 16'(rdy), 16'h1);
    sample_in = 12'($random(seed));
    sample_valid = 1'b1;
    @(posedge clock);
    q.push_back(sample_in);
    @(negedge clock);
    sample_valid = 1'b0;
  endtask : push
  // rd reads the old word during conversion, so the load is deferred
  task automatic conv(input bit rd, input int lo);
    host.convert(lo);
    repeat (8) @(negedge clock);
    check("hold", 16'(th), 16'h1);
    if (rd) host.read(16, w);
    if (rd) check("early", w, {4'h0, cur});
    repeat (24) @(negedge clock);
    check("track", 16'(th), 16'h0);
    if (q.size() > 0) cur = q.pop_front();
    host.read(16, w);
    check("frame", w, {4'h0, cur});
    repeat (80) @(negedge clock);
  endtask : conv
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    push();
    push();
    check("full", 16'(rdy), 16'h0);
    conv(1'b0, 8);
    conv(1'b1, 8);
    conv(1'b0, 8);
    repeat (3) begin
      push();
      conv(1'($random(seed)), 8);
    end
    host.read(20, w);
    check("extra", w, {cur, 4'h0});
    check("drive", 16'(oe_n), 16'h0);
    push();
    conv(1'b0, 200);
    final_report();
  end
endmodule : tb_sac_core
`default_nettype wire
